// *** cae_params.svh ***
// Functional notes
// - set bits: or immediate, znv, one cycle
// - clear bits: and with ff minus immediate
// - add/subtract one, znv only, carry kept
// - test: and with itself, znv, one cycle
// - zero register znv; all ones no flags
// - multiplies into pair one:zero, z c, two cycles
// - fractional multiplies shift left one, two cycles
// - jumps: relative two, pointer two, absolute three
// - calls three/four, returns four, flags kept
// - compare skip equal: skip next, 1/2/3 cycles
// - compares subtract unstored, set znvch, one cycle
// - skip on register bit clear or set
// - skip on io bit clear or set
// - generic flag branch on chosen status bit
// - branch equal on z one, not equal zero
// - carry branches: lower/high on c
// - minus/plus branches on negative flag
// - signed branches on n xor v
// - half carry branches on h flag
// - transfer branches on t flag
// - overflow branch taken when v is one
`ifndef CAE_PARAMS_SVH
`define CAE_PARAMS_SVH
`define CAE_FLAG_C 0
`define CAE_FLAG_Z 1
`define CAE_FLAG_N 2
`define CAE_FLAG_V 3
`define CAE_FLAG_H 5
`define CAE_FLAG_T 6
`define CAE_ALL_ONES 8'hff
`define CAE_INC_OVF 8'h80
`define CAE_DEC_OVF 8'h7f
`define CAE_CYC_ONE 3'h1
`define CAE_CYC_TWO 3'h2
`define CAE_CYC_THREE 3'h3
`define CAE_CYC_FOUR 3'h4
`define CAE_REG_CTRL 2'h0
`define CAE_REG_STATUS 2'h1
`define CAE_REG_FLAGS 2'h2
`define CAE_CTRL_RST 1'h1
`define CAE_FLAGS_RST 8'h00
`endif

// *** cae_pkg.sv ***
package cae_pkg;
	typedef enum logic [5:0] {
		op_set_bits_mask, op_clear_bits_mask, op_add_one,
		op_subtract_one, op_test_zero_minus, op_zero_register,
		op_load_all_ones, op_unsigned_product, op_signed_product,
		op_signed_by_unsigned_product, op_fractional_unsigned_product,
		op_fractional_signed_product, op_fractional_mixed_product,
		op_relative_jump, op_pointer_jump, op_absolute_jump,
		op_relative_subroutine_invoke, op_pointer_subroutine_invoke,
		op_absolute_subroutine_invoke, op_subroutine_exit,
		op_interrupt_exit, op_compare_skip_equal, op_compare_registers,
		op_compare_with_carry, op_compare_immediate,
		op_skip_reg_bit_clear, op_skip_reg_bit_high,
		op_skip_io_bit_clear, op_skip_io_bit_high,
		op_branch_flag_high, op_branch_flag_low, op_branch_equal,
		op_branch_not_equal, op_branch_carry_high, op_branch_carry_low,
		op_branch_same_or_higher, op_branch_lower, op_branch_minus,
		op_branch_plus, op_branch_greater_equal_signed,
		op_branch_less_signed, op_branch_half_carry_high,
		op_branch_half_carry_low, op_branch_transfer_high,
		op_branch_transfer_low, op_branch_overflow_high
	} cae_op_t;
	typedef enum logic {st_idle, st_run} cae_state_t;
endpackage : cae_pkg

// *** cae_mult.sv ***
module cae_mult
	import cae_pkg::*;
(
	input  logic        mclk,
	input  logic        reset,
	input  logic        ce,
	input  logic        start,
	input  logic [7:0]  a,
	input  logic [7:0]  b,
	input  logic        a_signed,
	input  logic        b_signed,
	input  logic        frac,
	output logic [15:0] prod_ff,
	output logic        carry_ff
);
	logic signed [8:0]  ext_a;
	logic signed [8:0]  ext_b;
	logic signed [17:0] full;
	logic        [15:0] raw;

	assign ext_a = {a_signed & a[7], a};
	assign ext_b = {b_signed & b[7], b};
	assign full  = ext_a * ext_b;
	assign raw   = full[15:0];

	always_ff @(posedge mclk) begin
		if (reset) begin
			prod_ff  <= 16'h0000;
			carry_ff <= 1'b0;
		end else if (ce && start) begin
			prod_ff  <= frac ? {raw[14:0], 1'b0} : raw;
			carry_ff <= raw[15];
		end
	end
endmodule : cae_mult

// *** cae_cond.sv ***
`include "cae_params.svh"
module cae_cond
	import cae_pkg::*;
(
	input  cae_op_t    op,
	input  logic [7:0] status_flags_register,
	input  logic [2:0] flag_sel,
	input  logic [7:0] rd_val,
	input  logic [7:0] rr_val,
	input  logic [2:0] bit_sel,
	input  logic       io_bit_val,
	output logic       is_branch,
	output logic       is_skip,
	output logic       cond_ok
);
	logic sgn_lt;

	assign sgn_lt = status_flags_register[`CAE_FLAG_N] ^ status_flags_register[`CAE_FLAG_V];

	always_comb begin
		is_branch = 1'b1;
		is_skip   = 1'b0;
		cond_ok   = 1'b0;
		case (op)
			op_branch_flag_high:  cond_ok = status_flags_register[flag_sel];
			op_branch_flag_low:   cond_ok = ~status_flags_register[flag_sel];
			op_branch_equal:      cond_ok = status_flags_register[`CAE_FLAG_Z];
			op_branch_not_equal:  cond_ok = ~status_flags_register[`CAE_FLAG_Z];
			op_branch_carry_high,
			op_branch_lower:      cond_ok = status_flags_register[`CAE_FLAG_C];
			op_branch_carry_low,
			op_branch_same_or_higher: cond_ok = ~status_flags_register[`CAE_FLAG_C];
			op_branch_minus:      cond_ok = status_flags_register[`CAE_FLAG_N];
			op_branch_plus:       cond_ok = ~status_flags_register[`CAE_FLAG_N];
			op_branch_greater_equal_signed: cond_ok = ~sgn_lt;
			op_branch_less_signed: cond_ok = sgn_lt;
			op_branch_half_carry_high: cond_ok = status_flags_register[`CAE_FLAG_H];
			op_branch_half_carry_low: cond_ok = ~status_flags_register[`CAE_FLAG_H];
			op_branch_transfer_high: cond_ok = status_flags_register[`CAE_FLAG_T];
			op_branch_transfer_low: cond_ok = ~status_flags_register[`CAE_FLAG_T];
			op_branch_overflow_high: cond_ok = status_flags_register[`CAE_FLAG_V];
			op_compare_skip_equal: begin
				is_branch = 1'b0;
				is_skip   = 1'b1;
				cond_ok   = (rd_val == rr_val);
			end
			op_skip_reg_bit_clear: begin
				is_branch = 1'b0;
				is_skip   = 1'b1;
				cond_ok   = ~rr_val[bit_sel];
			end
			op_skip_reg_bit_high: begin
				is_branch = 1'b0;
				is_skip   = 1'b1;
				cond_ok   = rr_val[bit_sel];
			end
			op_skip_io_bit_clear: begin
				is_branch = 1'b0;
				is_skip   = 1'b1;
				cond_ok   = ~io_bit_val;
			end
			op_skip_io_bit_high: begin
				is_branch = 1'b0;
				is_skip   = 1'b1;
				cond_ok   = io_bit_val;
			end
			default: is_branch = 1'b0;
		endcase
	end
endmodule : cae_cond

// *** cae_exec.sv ***
`include "cae_params.svh"
module cae_exec
	import cae_pkg::*;
#(
	parameter int PC_W = 13
)
(
	input  logic            mclk,
	input  logic            reset,
	input  logic            ce,
	input  logic            start,
	input  cae_op_t         op,
	input  logic [7:0]      rd_val,
	input  logic [7:0]      rr_val,
	input  logic [7:0]      imm,
	input  logic [2:0]      bit_sel,
	input  logic [2:0]      flag_sel,
	input  logic            io_bit_val,
	input  logic            next_two_word,
	input  logic [11:0]     offset,
	input  logic [PC_W-1:0] abs_addr,
	input  logic [15:0]     z_ptr,
	input  logic [PC_W-1:0] ret_addr,
	input  logic [PC_W-1:0] pc,
	input  logic [1:0]      reg_addr,
	input  logic [7:0]      reg_wdata,
	input  logic            reg_wr,
	input  logic            reg_rd,
	output logic [7:0]      reg_rdata_ff,
	output logic            busy_ff,
	output logic            done_ff,
	output logic [15:0]     result_ff,
	output logic            res_wr_ff,
	output logic            res_pair_ff,
	output logic [7:0]      status_flags_register_ff,
	output logic [PC_W-1:0] pc_next_ff,
	output logic            push_ff,
	output logic [PC_W-1:0] push_addr_ff,
	output logic            pop_ff
);
	function automatic logic [7:0] f_znv(input logic [7:0] s,
		input logic [7:0] r, input logic v);
		logic [7:0] f;
		f = s;
		f[`CAE_FLAG_Z] = (r == 8'h00);
		f[`CAE_FLAG_N] = r[7];
		f[`CAE_FLAG_V] = v;
		return f;
	endfunction : f_znv

	function automatic logic f_is_mul(input cae_op_t o);
		return o inside {op_unsigned_product, op_signed_product,
			op_signed_by_unsigned_product, op_fractional_unsigned_product,
			op_fractional_signed_product, op_fractional_mixed_product};
	endfunction : f_is_mul

	cae_state_t      state_ff;
	cae_state_t      nxt_state;
	logic [2:0]      cnt_ff;
	logic [2:0]      nxt_cnt;
	logic            enable_ff;
	logic [2:0]      last_cyc_ff;
	logic [7:0]      pend_r_ff;
	logic [7:0]      pend_status_flags_register_ff;
	logic            pend_wr_ff;
	logic            pend_mul_ff;
	logic [PC_W-1:0] pend_pc_ff;
	logic            pend_push_ff;
	logic [PC_W-1:0] pend_paddr_ff;
	logic            pend_pop_ff;

	logic            take;
	logic            fin;
	logic            is_branch;
	logic            is_skip;
	logic            cond_ok;
	logic [15:0]     prod_ff;
	logic            mul_c_ff;
	logic            mul_a_s;
	logic            mul_b_s;
	logic            mul_frac;
	logic [PC_W-1:0] pc_inc1;
	logic [PC_W-1:0] pc_inc2;
	logic [PC_W-1:0] pc_inc3;
	logic [PC_W-1:0] pc_rel;
	logic [7:0]      cmp_b;
	logic            cmp_cin;
	logic [8:0]      diff;
	logic [7:0]      dr;
	logic            d_c;
	logic            d_h;
	logic            d_v;
	logic [7:0]      alu_r;
	logic [7:0]      alu_status_flags_register;
	logic            alu_wr;
	logic [PC_W-1:0] alu_pc;
	logic            alu_push;
	logic [PC_W-1:0] alu_paddr;
	logic            alu_pop;
	logic [2:0]      alu_cyc;
	logic [7:0]      fin_r;
	logic [7:0]      fin_status_flags_register;
	logic            fin_mul;
	logic [7:0]      mul_status_flags_register;
	logic [7:0]      rd_mux;
	logic            flags_wr;

	assign take = ce && start && state_ff == st_idle && enable_ff;
	assign fin  = take ? (alu_cyc == `CAE_CYC_ONE)
		: (state_ff == st_run && cnt_ff == 3'h1);

	assign pc_inc1 = pc + PC_W'(1);
	assign pc_inc2 = pc + PC_W'(2);
	assign pc_inc3 = pc + PC_W'(3);
	assign pc_rel  = pc + PC_W'(signed'(offset)) + PC_W'(1);

	assign mul_a_s  = op inside {op_signed_product,
		op_signed_by_unsigned_product, op_fractional_signed_product,
		op_fractional_mixed_product};
	assign mul_b_s  = op inside {op_signed_product,
		op_fractional_signed_product};
	assign mul_frac = op inside {op_fractional_unsigned_product,
		op_fractional_signed_product, op_fractional_mixed_product};

	// compare path: difference is never written back
	assign cmp_b   = (op == op_compare_immediate) ? imm : rr_val;
	assign cmp_cin = (op == op_compare_with_carry) & status_flags_register_ff[`CAE_FLAG_C];
	assign diff    = {1'b0, rd_val} - {1'b0, cmp_b} - {8'h00, cmp_cin};
	assign dr      = diff[7:0];
	assign d_c = (~rd_val[7] & cmp_b[7]) | (cmp_b[7] & dr[7])
		| (dr[7] & ~rd_val[7]);
	assign d_h = (~rd_val[3] & cmp_b[3]) | (cmp_b[3] & dr[3])
		| (dr[3] & ~rd_val[3]);
	assign d_v = (rd_val[7] & ~cmp_b[7] & ~dr[7])
		| (~rd_val[7] & cmp_b[7] & dr[7]);

	cae_cond u_cond (
		.op         (op),
		.status_flags_register       (status_flags_register_ff),
		.flag_sel   (flag_sel),
		.rd_val     (rd_val),
		.rr_val     (rr_val),
		.bit_sel    (bit_sel),
		.io_bit_val (io_bit_val),
		.is_branch  (is_branch),
		.is_skip    (is_skip),
		.cond_ok    (cond_ok)
	);

	cae_mult u_mult (
		.mclk     (mclk),
		.reset    (reset),
		.ce       (ce),
		.start    (take && f_is_mul(op)),
		.a        (rd_val),
		.b        (rr_val),
		.a_signed (mul_a_s),
		.b_signed (mul_b_s),
		.frac     (mul_frac),
		.prod_ff  (prod_ff),
		.carry_ff (mul_c_ff)
	);

	always_comb begin
		alu_r     = rd_val;
		alu_status_flags_register  = status_flags_register_ff;
		alu_wr    = 1'b0;
		alu_pc    = pc_inc1;
		alu_push  = 1'b0;
		alu_paddr = pc_inc1;
		alu_pop   = 1'b0;
		alu_cyc   = `CAE_CYC_ONE;
		case (op)
			op_set_bits_mask: begin
				alu_r    = rd_val | imm;
				alu_wr   = 1'b1;
				alu_status_flags_register = f_znv(status_flags_register_ff, alu_r, 1'b0);
			end
			op_clear_bits_mask: begin
				alu_r    = rd_val & (`CAE_ALL_ONES - imm);
				alu_wr   = 1'b1;
				alu_status_flags_register = f_znv(status_flags_register_ff, alu_r, 1'b0);
			end
			op_add_one: begin
				alu_r    = rd_val + 8'h01;
				alu_wr   = 1'b1;
				alu_status_flags_register = f_znv(status_flags_register_ff, alu_r, alu_r == `CAE_INC_OVF);
			end
			op_subtract_one: begin
				alu_r    = rd_val - 8'h01;
				alu_wr   = 1'b1;
				alu_status_flags_register = f_znv(status_flags_register_ff, alu_r, alu_r == `CAE_DEC_OVF);
			end
			op_test_zero_minus: begin
				alu_r    = rd_val & rd_val;
				alu_status_flags_register = f_znv(status_flags_register_ff, alu_r, 1'b0);
			end
			op_zero_register: begin
				alu_r    = rd_val ^ rd_val;
				alu_wr   = 1'b1;
				alu_status_flags_register = f_znv(status_flags_register_ff, alu_r, 1'b0);
			end
			op_load_all_ones: begin
				alu_r  = `CAE_ALL_ONES;
				alu_wr = 1'b1;
			end
			op_unsigned_product, op_signed_product,
			op_signed_by_unsigned_product, op_fractional_unsigned_product,
			op_fractional_signed_product, op_fractional_mixed_product: begin
				alu_wr  = 1'b1;
				alu_cyc = `CAE_CYC_TWO;
			end
			op_relative_jump: begin
				alu_pc  = pc_rel;
				alu_cyc = `CAE_CYC_TWO;
			end
			op_pointer_jump: begin
				alu_pc  = z_ptr[PC_W-1:0];
				alu_cyc = `CAE_CYC_TWO;
			end
			op_absolute_jump: begin
				alu_pc  = abs_addr;
				alu_cyc = `CAE_CYC_THREE;
			end
			op_relative_subroutine_invoke: begin
				alu_pc   = pc_rel;
				alu_push = 1'b1;
				alu_cyc  = `CAE_CYC_THREE;
			end
			op_pointer_subroutine_invoke: begin
				alu_pc   = z_ptr[PC_W-1:0];
				alu_push = 1'b1;
				alu_cyc  = `CAE_CYC_THREE;
			end
			op_absolute_subroutine_invoke: begin
				alu_pc    = abs_addr;
				alu_push  = 1'b1;
				alu_paddr = pc_inc2;
				alu_cyc   = `CAE_CYC_FOUR;
			end
			op_subroutine_exit, op_interrupt_exit: begin
				alu_pc  = ret_addr;
				alu_pop = 1'b1;
				alu_cyc = `CAE_CYC_FOUR;
			end
			op_compare_registers, op_compare_with_carry,
			op_compare_immediate: begin
				alu_status_flags_register = f_znv(status_flags_register_ff, dr, d_v);
				alu_status_flags_register[`CAE_FLAG_C] = d_c;
				alu_status_flags_register[`CAE_FLAG_H] = d_h;
				if (op == op_compare_with_carry)
					alu_status_flags_register[`CAE_FLAG_Z] = (dr == 8'h00)
						& status_flags_register_ff[`CAE_FLAG_Z];
			end
			default: begin
				if (is_skip && cond_ok) begin
					alu_pc  = next_two_word ? pc_inc3 : pc_inc2;
					alu_cyc = next_two_word ? `CAE_CYC_THREE
						: `CAE_CYC_TWO;
				end else if (is_branch && cond_ok) begin
					alu_pc  = pc_rel;
					alu_cyc = `CAE_CYC_TWO;
				end
			end
		endcase
	end

	// finishing values: straight from decode on a one cycle op
	assign fin_mul  = !take && pend_mul_ff;
	assign mul_status_flags_register = {pend_status_flags_register_ff[7:2], prod_ff == 16'h0000, mul_c_ff};
	assign fin_r    = take ? alu_r : pend_r_ff;
	assign fin_status_flags_register = take ? alu_status_flags_register : (fin_mul ? mul_status_flags_register : pend_status_flags_register_ff);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		if (take && alu_cyc != `CAE_CYC_ONE) begin
			nxt_state = st_run;
			nxt_cnt   = alu_cyc - 3'h1;
		end else if (state_ff == st_run) begin
			nxt_cnt = cnt_ff - 3'h1;
			if (cnt_ff == 3'h1)
				nxt_state = st_idle;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_ff <= st_idle;
			cnt_ff   <= 3'h0;
			busy_ff  <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			busy_ff  <= (nxt_state == st_run);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pend_r_ff     <= 8'h00;
			pend_status_flags_register_ff  <= `CAE_FLAGS_RST;
			pend_wr_ff    <= 1'b0;
			pend_mul_ff   <= 1'b0;
			pend_pc_ff    <= '0;
			pend_push_ff  <= 1'b0;
			pend_paddr_ff <= '0;
			pend_pop_ff   <= 1'b0;
			last_cyc_ff   <= 3'h0;
		end else if (ce && take) begin
			pend_r_ff     <= alu_r;
			pend_status_flags_register_ff  <= alu_status_flags_register;
			pend_wr_ff    <= alu_wr;
			pend_mul_ff   <= f_is_mul(op);
			pend_pc_ff    <= alu_pc;
			pend_push_ff  <= alu_push;
			pend_paddr_ff <= alu_paddr;
			pend_pop_ff   <= alu_pop;
			last_cyc_ff   <= alu_cyc;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			done_ff      <= 1'b0;
			res_wr_ff    <= 1'b0;
			res_pair_ff  <= 1'b0;
			result_ff    <= 16'h0000;
			pc_next_ff   <= '0;
			push_ff      <= 1'b0;
			push_addr_ff <= '0;
			pop_ff       <= 1'b0;
		end else if (ce) begin
			done_ff   <= fin;
			res_wr_ff <= fin && (take ? alu_wr : pend_wr_ff);
			push_ff   <= fin && (take ? alu_push : pend_push_ff);
			pop_ff    <= fin && (take ? alu_pop : pend_pop_ff);
			if (fin) begin
				res_pair_ff  <= fin_mul;
				result_ff    <= fin_mul ? prod_ff : {8'h00, fin_r};
				pc_next_ff   <= take ? alu_pc : pend_pc_ff;
				push_addr_ff <= take ? alu_paddr : pend_paddr_ff;
			end
		end
	end

	// flag register: an instruction update wins over a software write
	assign flags_wr = reg_wr && reg_addr == `CAE_REG_FLAGS;

	always_ff @(posedge mclk) begin
		if (reset) begin
			status_flags_register_ff   <= `CAE_FLAGS_RST;
			enable_ff <= `CAE_CTRL_RST;
		end else if (ce) begin
			if (fin)
				status_flags_register_ff <= fin_status_flags_register;
			else if (flags_wr)
				status_flags_register_ff <= reg_wdata;
			if (reg_wr && reg_addr == `CAE_REG_CTRL)
				enable_ff <= reg_wdata[0];
		end
	end

	always_comb begin
		case (reg_addr)
			`CAE_REG_CTRL:   rd_mux = {7'h00, enable_ff};
			`CAE_REG_STATUS: rd_mux = {4'h0, last_cyc_ff, busy_ff};
			`CAE_REG_FLAGS:  rd_mux = status_flags_register_ff;
			default:         rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset)
			reg_rdata_ff <= 8'h00;
		else if (ce)
			reg_rdata_ff <= reg_rd ? rd_mux : 8'h00;
	end

	property p_set_mask;
		@(posedge mclk) disable iff (reset)
		take && op == op_set_bits_mask |=> done_ff && res_wr_ff
			&& result_ff[7:0] == ($past(rd_val) | $past(imm));
	endproperty
	a_set_mask: assert property (p_set_mask)
		else $error("set bits result wrong");

	property p_clr_mask;
		@(posedge mclk) disable iff (reset)
		take && op == op_clear_bits_mask |=>
			result_ff[7:0] == ($past(rd_val) & ~$past(imm))
			&& status_flags_register_ff[`CAE_FLAG_V] == 1'b0;
	endproperty
	a_clr_mask: assert property (p_clr_mask)
		else $error("clear bits result wrong");

	property p_inc_carry;
		@(posedge mclk) disable iff (reset)
		take && op inside {op_add_one, op_subtract_one} |=>
			status_flags_register_ff[`CAE_FLAG_C] == $past(status_flags_register_ff[`CAE_FLAG_C]) && done_ff;
	endproperty
	a_inc_carry: assert property (p_inc_carry)
		else $error("increment touched carry");

	property p_ones;
		@(posedge mclk) disable iff (reset)
		take && op == op_load_all_ones |=>
			result_ff[7:0] == 8'hff && status_flags_register_ff == $past(status_flags_register_ff);
	endproperty
	a_ones: assert property (p_ones)
		else $error("all ones load wrong");

	property p_mul_time;
		@(posedge mclk) disable iff (reset)
		take && f_is_mul(op) |=> !done_ff ##0 ce |=> done_ff
			&& res_pair_ff && status_flags_register_ff[`CAE_FLAG_C] == mul_c_ff;
	endproperty
	a_mul_time: assert property (p_mul_time)
		else $error("multiply timing wrong");

	property p_frac_lsb;
		@(posedge mclk) disable iff (reset)
		take && mul_frac ##1 ce |=> result_ff[0] == 1'b0;
	endproperty
	a_frac_lsb: assert property (p_frac_lsb)
		else $error("fractional lsb set");

	property p_abs_jump;
		@(posedge mclk) disable iff (reset)
		take && op == op_absolute_jump ##1 ce ##1 ce |=>
			done_ff && pc_next_ff == $past(abs_addr, 3);
	endproperty
	a_abs_jump: assert property (p_abs_jump)
		else $error("absolute jump wrong");

	property p_cmp_nowr;
		@(posedge mclk) disable iff (reset)
		take && op inside {op_compare_registers, op_compare_immediate}
			|=> done_ff && !res_wr_ff
			&& status_flags_register_ff[`CAE_FLAG_Z] == ($past(diff[7:0]) == 8'h00);
	endproperty
	a_cmp_nowr: assert property (p_cmp_nowr)
		else $error("compare stored or flag wrong");

	property p_br_not;
		@(posedge mclk) disable iff (reset)
		take && is_branch && !cond_ok |=>
			done_ff && pc_next_ff == $past(pc) + PC_W'(1);
	endproperty
	a_br_not: assert property (p_br_not)
		else $error("untaken branch wrong");

	property p_call_flags;
		@(posedge mclk) disable iff (reset)
		take && op == op_absolute_subroutine_invoke ##1 ce[*3]
			|=> done_ff && push_ff && status_flags_register_ff == $past(status_flags_register_ff, 4);
	endproperty
	a_call_flags: assert property (p_call_flags)
		else $error("direct call timing wrong");
endmodule : cae_exec

// *** cae_exec_bench.sv ***
module cae_exec_bench
	import cae_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {
		int          n, t;
		logic        w, pr, ps, pp;
		logic [15:0] r;
		logic [7:0]  f;
		logic [12:0] pn, pa;
	} cae_exp_t;
	logic        mclk = 1'h0, reset = 1'h1, ce = 1'h1, start = 1'h0;
	logic        io_bit_val = 1'h0, next_two_word = 1'h0;
	logic        reg_wr = 1'h0, reg_rd = 1'h0, rd_d = 1'h0;
	cae_op_t     op = op_add_one;
	logic [7:0]  rd_val = '0, rr_val = '0, imm = '0, reg_wdata = '0, fl = '0;
	logic [2:0]  bit_sel = '0, flag_sel = '0;
	logic [1:0]  reg_addr = '0;
	logic [11:0] offset = '0;
	logic [12:0] abs_addr = '0, ret_addr = '0, pc = '0;
	logic [12:0] pc_next_ff, push_addr_ff;
	logic [15:0] z_ptr = '0, result_ff;
	logic [7:0]  reg_rdata_ff, status_flags_register_ff;
	logic        busy_ff, done_ff, res_wr_ff, res_pair_ff, push_ff, pop_ff;
	int          cyc = 0, mismatches = 0, n_checks = 0;
	int          jn[8] = '{2, 2, 3, 3, 3, 4, 4, 4};
	cae_exp_t    e;
	cae_exp_t    q[$];
	logic [7:0]  rq[$];
	logic [7:0]  bnd[4] = '{8'h7f, 8'h80, 8'h00, 8'hff};

	always #2.5 mclk = ~mclk;

	cae_exec #(.PC_W(13)) cae_exec_i (
		.mclk, .reset, .ce, .start, .op, .rd_val, .rr_val, .imm, .bit_sel,
		.flag_sel, .io_bit_val, .next_two_word, .offset, .abs_addr, .z_ptr,
		.ret_addr, .pc, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata_ff, .busy_ff, .done_ff, .result_ff, .res_wr_ff,
		.res_pair_ff, .status_flags_register_ff, .pc_next_ff, .push_ff, .push_addr_ff, .pop_ff
	);

	task automatic chk(input bit ok, input string m);
		n_checks++;
		if (!ok) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	task automatic wrr(input logic [1:0] a, input logic [7:0] d);
		if (a == 2'h2)
			fl = d;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
		@(posedge mclk);
	endtask : wrr

	task automatic rdr(input logic [1:0] a, input logic [7:0] d);
		rq.push_back(d);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		@(posedge mclk);
	endtask : rdr

	// expectation from the operands the design sampled at this edge
	function automatic cae_exp_t calc();
		cae_exp_t    x;
		int          o, sa, sb;
		logic        tk, c;
		logic [7:0]  r, b;
		logic [15:0] p;
		logic [12:0] rel;
		o = op;
		x = '{default: '0};
		x.n = 1;
		x.f = fl;
		x.pn = pc + 13'h1;
		rel = pc + 13'(signed'(offset)) + 13'h1;
		b = (o == 24) ? imm : rr_val;
		c = (o == 23) & fl[0];
		sa = rd_val;
		sb = rr_val;
		if (o inside {8, 9, 11, 12})
			sa = $signed(rd_val);
		if (o inside {8, 11})
			sb = $signed(rr_val);
		p = 16'(sa * sb);
		case (o)
			0: r = rd_val | imm;
			1: r = rd_val & (8'hff - imm);
			2: r = rd_val + 8'h01;
			3: r = rd_val - 8'h01;
			4: r = rd_val & rd_val;
			5: r = rd_val ^ rd_val;
			6: r = 8'hff;
			default: r = rd_val - b - {7'h00, c};
		endcase
		case (o)
			21: tk = rd_val == rr_val;
			25, 26: tk = rr_val[bit_sel];
			27, 28: tk = io_bit_val;
			29, 30: tk = fl[flag_sel];
			31, 32: tk = fl[1];
			33, 34, 35, 36: tk = fl[0];
			37, 38: tk = fl[2];
			39, 40: tk = fl[2] ^ fl[3];
			41, 42: tk = fl[5];
			43, 44: tk = fl[6];
			default: tk = fl[3];
		endcase
		if (o inside {25, 27, 30, 32, 34, 35, 38, 39, 42, 44})
			tk = !tk;
		if (o <= 6) begin
			x.w = o != 4;
			x.r = {8'h00, r};
			if (o != 6)
				x.f[3:1] = {o == 2 ? r == 8'h80 : o == 3 && r == 8'h7f,
					r[7], r == 8'h00};
		end else if (o <= 12) begin
			x.n = 2;
			x.w = 1'h1;
			x.pr = 1'h1;
			x.r = (o > 9) ? p << 1 : p;
			x.f[1:0] = {x.r == 16'h0000, p[15]};
		end else if (o <= 20) begin
			x.n = jn[o - 13];
			x.pn = o inside {13, 16} ? rel : o inside {14, 17} ? z_ptr[12:0]
				: o inside {15, 18} ? abs_addr : ret_addr;
			x.ps = o inside {[16:18]};
			x.pa = pc + ((o == 18) ? 13'h2 : 13'h1);
			x.pp = o > 18;
		end else if (o inside {[22:24]}) begin
			x.f[5] = int'(rd_val[3:0]) < int'(b[3:0]) + c;
			x.f[3:0] = {rd_val[7] & ~b[7] & ~r[7] | ~rd_val[7] & b[7] & r[7],
				r[7], r == 8'h00 && (o != 23 || fl[1]),
				int'(rd_val) < int'(b) + c};
		end else if (o <= 28) begin
			x.n = tk ? 2 + next_two_word : 1;
			x.pn = pc + 13'(x.n);
		end else begin
			x.n = tk ? 2 : 1;
			x.pn = tk ? rel : pc + 13'h1;
		end
		return x;
	endfunction : calc

	task automatic go();
		cae_exp_t x;
		int       k;
		start <= 1'h1;
		@(posedge mclk);
		x = calc();
		x.t = cyc;
		fl = x.f;
		q.push_back(x);
		start <= 1'h0;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
			chk(busy_ff === ~done_ff, "busy flag");
		end while (done_ff !== 1'h1 && k < 9);
		chk(k < 9, "no completion");
	endtask : go

	// boundary operands first, then random ones, flags reshuffled often
	task automatic run_range(input int lo, input int hi, input int reps);
		int          w;
		logic [31:0] v, u;
		w = hi - lo + 1;
		for (int i = 0; i < reps; i++) begin
			if (i % 3 == 2)
				wrr(2'h2, 8'($urandom));
			v = $urandom;
			u = $urandom;
			op <= cae_op_t'(lo + i % w);
			rd_val <= (i < 4 * w) ? bnd[i / w] : v[7:0];
			rr_val <= (i < 2 * w) ? bnd[i / w] : v[15:8];
			imm <= (i < 2 * w) ? bnd[i / w] : v[23:16];
			{bit_sel, flag_sel, io_bit_val, next_two_word} <= v[31:24];
			offset <= (lo >= 29) ? {{5{u[6]}}, u[6:0]} : u[11:0];
			pc <= u[24:12];
			abs_addr <= v[12:0] ^ u[12:0];
			z_ptr <= u[31:16];
			ret_addr <= u[28:16];
			go();
		end
		$display("ops %0d to %0d done", lo, hi);
	endtask : run_range

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		rd_d <= reg_rd;
		if (cyc == 4000) begin
			mismatches++;
			print_verdict();
		end
		if (rd_d)
			chk(reg_rdata_ff === rq.pop_front(), "read data");
		if (done_ff === 1'h1) begin
			chk(q.size() > 0, "unexpected completion");
			if (q.size() > 0) begin
				e = q.pop_front();
				chk(cyc - e.t == e.n, "cycle count");
				chk(status_flags_register_ff === e.f, "flags");
				chk(pc_next_ff === e.pn, "next pc");
				chk({res_wr_ff, push_ff, pop_ff} === {e.w, e.ps, e.pp},
					"strobes");
				if (e.w)
					chk(res_pair_ff === e.pr && (e.pr ? result_ff === e.r
						: result_ff[7:0] === e.r[7:0]), "result");
				if (e.ps)
					chk(push_addr_ff === e.pa, "return address");
			end
		end
	end

	initial begin
		void'($urandom(32'h778b_a1ad));
		repeat (4) @(posedge mclk);
		reset <= 1'h0;
		@(posedge mclk);
		rdr(2'h0, 8'h01);
		rdr(2'h2, 8'h00);
		wrr(2'h3, 8'h5a);
		rdr(2'h3, 8'h00);
		wrr(2'h2, 8'ha5);
		rdr(2'h2, 8'ha5);
		$display("register port done");
		run_range(0, 6, 42);
		run_range(7, 12, 36);
		run_range(13, 20, 16);
		rdr(2'h1, 8'h08);
		run_range(21, 28, 40);
		run_range(29, 36, 48);
		run_range(37, 45, 54);
		// disabled or frozen requests must be dropped silently
		wrr(2'h0, 8'h00);
		start <= 1'h1;
		@(posedge mclk);
		start <= 1'h0;
		repeat (3) @(posedge mclk);
		wrr(2'h0, 8'h01);
		ce <= 1'h0;
		start <= 1'h1;
		@(posedge mclk);
		start <= 1'h0;
		ce <= 1'h1;
		repeat (3) @(posedge mclk);
		go();
		$display("refusal done");
		print_verdict();
	end
endmodule : cae_exec_bench
